// ===== inc/imcv_defs.svh
/*
  constants of the image convolver: line segment sizes, window shape,
  saturation codes and field widths.
  assumes: included by bare name from the package and the design files.
*/
`ifndef IMCV_DEFS_SVH
`define IMCV_DEFS_SVH

// ****************************************************************
// line store
// ****************************************************************
`define IMCV_NSEG        8
`define IMCV_SEG_DEPTH   512
`define IMCV_SEG_AW      9
`define IMCV_LEN_W       11
`define IMCV_MAX_LEN4    11'h400
`define IMCV_MAX_LEN8    11'h200

// ****************************************************************
// window and multiplier array
// ****************************************************************
`define IMCV_WIN         8
`define IMCV_NMUL        16
`define IMCV_NCOEF       64
`define IMCV_ACC_W       32

// ****************************************************************
// gain stage and saturation
// ****************************************************************
`define IMCV_FIELD_W     20
`define IMCV_GPROD_W     24
`define IMCV_SAT_NONE    2'h0
`define IMCV_SAT_DISPLAY 2'h1
`define IMCV_SAT_SYMM    2'h2
`define IMCV_POS_MAX     16'h7fff
`define IMCV_NEG_MAX     16'h8000

`endif

// ===== inc/imcv_pkg.sv
/*
  types shared by the convolver core: configuration and coefficient
  write carriers.
  assumes: imcv_defs.svh sits on the include path.
*/
`include "imcv_defs.svh"

package imcv_pkg;

  // static configuration, held steady by the surrounding logic
  typedef struct packed {
    logic                   quad_clk;
    logic                   deep8;
    logic                   pix16;
    logic                   aux_drive;
    logic                   b_first_skip;
    logic [1:0]             saturation_mode_bits;
    logic [1:0]             field_select_bits;
    logic [3:0]             gain;
    logic [15:0]            threshold;
    logic [`IMCV_LEN_W-1:0] line_len;
  } imcv_cfg_s;

  typedef struct packed {
    logic       we;
    logic [5:0] addr;
    logic [7:0] data;
  } imcv_coef_wr_s;

endpackage

// ===== rtl/imcv_line_seg.sv
/*
  one 512-entry line delay segment held in flip-flops.
  assumes: en_i is the one-cycle pixel enable; len_i is at most 512,
  and a length of zero makes the segment a plain wire.
*/
`timescale 1ns/1ps
`include "imcv_defs.svh"

module imcv_line_seg (
  // clock and reset
  input  wire logic                   clk_sys_i,
  input  wire logic                   sys_rst_i,
  // control
  input  wire logic                   en_i,
  input  wire logic [`IMCV_LEN_W-1:0] len_i,
  // data
  input  wire logic [7:0]             din_i,
  output logic      [7:0]             dout_o
);

  logic [7:0]               mem_ff [`IMCV_SEG_DEPTH];
  logic [`IMCV_SEG_AW-1:0]  ptr_ff;
  logic [`IMCV_SEG_AW-1:0]  nxt_ptr;
  logic [`IMCV_LEN_W-1:0]   ptr_ext;

  // read old contents, then overwrite the same address
  assign dout_o  = (len_i == '0) ? din_i : mem_ff[ptr_ff];
  assign ptr_ext = {2'h0, ptr_ff};

  always_comb begin
    nxt_ptr = ptr_ff;
    if (en_i) begin
      if (ptr_ext + 11'h001 >= len_i) begin
        nxt_ptr = '0;
      end else begin
        nxt_ptr = ptr_ff + 9'h001;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ptr_ff <= '0;
    end else begin
      ptr_ff <= nxt_ptr;
    end
  end

  // storage is cleared by reset so no unknown ever reaches the window taps
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < `IMCV_SEG_DEPTH; i++) begin
        mem_ff[i] <= '0;
      end
    end else if (en_i) begin
      mem_ff[ptr_ff] <= din_i;
    end
  end

endmodule // imcv_line_seg

// ===== rtl/imcv_core.sv
/*
  two-dimensional convolver core: line delays, window, multicycled
  multiplier array, 32-bit accumulation, gain, saturation, threshold.
  assumes: pixel buses are synchronous to clk_sys_i and follow
  pix_tick_o; configuration is held steady while frames run.
*/
// How it works
// - weighted window sum, one result per pixel
// - 32-bit signed accumulation never overflows
// - gain product bits 19:4 drive result bus
// - display mode: negatives zero, overflow peak
// - symmetric mode clamps both overflow directions
// - flag raised on gain stage overflow
// - compare output against programmed 16-bit threshold
// - sixteen 8x8 multipliers, 16-bit products
// - internal clock two or four per pixel
// - 4x4 array gives 4x8 or 8x8
// - 16-bit signed pixels halve multipliers
// - four-deep 8-bit: four 1024-pixel delays
// - eight-deep or 16-bit: 512 pixel limit
// - pin switches group B first delay
// - aux bus input at reset, output by bit
// - skip bit bypasses, pin then ignored
// - field select picks one of four fields
// - 4-bit gain, 24-bit product, middle 16
`timescale 1ns/1ps
`include "imcv_defs.svh"

module imcv_core import imcv_pkg::*; (
  // clock and reset
  input  wire logic          clk_sys_i,
  input  wire logic          sys_rst_i,
  // configuration and coefficient load
  input  wire imcv_cfg_s     cfg_i,
  input  wire imcv_coef_wr_s coef_wr_i,
  // pixel inputs
  input  wire logic [15:0]   main_px_i,
  input  wire logic [7:0]    aux_pixel_bus_i,
  input  wire logic          bypass_i,
  // auxiliary pixel bus drive
  output logic      [7:0]    aux_pixel_bus_o,
  output logic               aux_pixel_bus_oe_o,
  // pixel timing
  output logic               pix_tick_o,
  // results
  output logic      [15:0]   result_output_bus_o,
  output logic               gain_overflow_flag_o,
  output logic               above_thresh_o,
  output logic               result_valid_o
);

  // ****************************************************************
  // bypass pin synchroniser
  // ****************************************************************
  logic [2:0] byp_sync_ff;
  logic [2:0] nxt_byp_sync;
  logic       byp_ff;
  logic       nxt_byp;

  always_comb begin
    nxt_byp_sync = {byp_sync_ff[1:0], bypass_i};
    nxt_byp      = (byp_sync_ff[2] == byp_sync_ff[1]) ? byp_sync_ff[1] : byp_ff;
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      byp_sync_ff <= '0;
      byp_ff      <= 1'b0;
    end else begin
      byp_sync_ff <= nxt_byp_sync;
      byp_ff      <= nxt_byp;
    end
  end

  // ****************************************************************
  // pixel rate divider
  // ****************************************************************
  logic [1:0] ph_ff;
  logic [1:0] nxt_ph;
  logic [1:0] last_ph;
  logic       pix_en;
  logic       tick_ff;
  logic       nxt_tick;
  logic       deep8;

  // eight-deep needs all four passes, so it only acts at x4
  assign deep8   = cfg_i.deep8 & cfg_i.quad_clk & ~cfg_i.pix16;
  assign last_ph = cfg_i.quad_clk ? 2'h3 : 2'h1;
  assign pix_en  = (ph_ff == last_ph);

  always_comb begin
    nxt_ph   = pix_en ? 2'h0 : ph_ff + 2'h1;
    nxt_tick = (nxt_ph == last_ph);
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ph_ff   <= '0;
      tick_ff <= 1'b0;
    end else begin
      ph_ff   <= nxt_ph;
      tick_ff <= nxt_tick;
    end
  end

  // ****************************************************************
  // coefficient store
  // ****************************************************************
  logic [7:0] coef_ff [`IMCV_NCOEF];

  // unused positions rely on zero loads
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < `IMCV_NCOEF; i++) begin
        coef_ff[i] <= '0;
      end
    end else if (coef_wr_i.we) begin
      coef_ff[coef_wr_i.addr] <= coef_wr_i.data;
    end
  end

  // ****************************************************************
  // line delays
  // ****************************************************************
  logic [7:0]             seg_in  [`IMCV_NSEG];
  logic [7:0]             seg_out [`IMCV_NSEG];
  logic [`IMCV_LEN_W-1:0] seg_len [`IMCV_NSEG];
  logic [`IMCV_LEN_W-1:0] len_max;
  logic [`IMCV_LEN_W-1:0] len_cl;
  logic [`IMCV_LEN_W-1:0] len_a;
  logic [15:0]            px;
  logic [15:0]            a_end;
  logic [15:0]            b_src;
  logic [15:0]            row [`IMCV_WIN];
  logic                   b_byp;
  logic                   split;

  genvar gs;
  generate
    for (gs = 0; gs < `IMCV_NSEG; gs++) begin : g_seg
      imcv_line_seg u_seg (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .en_i      (pix_en),
        .len_i     (seg_len[gs]),
        .din_i     (seg_in[gs]),
        .dout_o    (seg_out[gs])
      );
    end
  endgenerate

  // 512 limit when deep or wide
  assign len_max = (deep8 | cfg_i.pix16) ? `IMCV_MAX_LEN8 : `IMCV_MAX_LEN4;
  assign len_cl  = (cfg_i.line_len > len_max) ? len_max : cfg_i.line_len;
  assign len_a   = (len_cl > `IMCV_MAX_LEN8) ? `IMCV_MAX_LEN8 : len_cl;
  assign split   = ~deep8 & ~cfg_i.pix16;
  // wide pixels on the main bus
  assign px      = cfg_i.pix16 ? main_px_i : {8'h00, main_px_i[7:0]};
  assign b_byp   = cfg_i.b_first_skip | byp_ff;

  always_comb begin
    for (int i = 0; i < `IMCV_NSEG; i++) begin
      seg_len[i] = len_a;
      seg_in[i]  = '0;
      row[i]     = '0;
    end
    if (split) begin
      for (int i = 1; i < `IMCV_NSEG; i += 2) begin
        seg_len[i] = len_cl - len_a;
      end
    end
    if (cfg_i.pix16) begin
      a_end = {seg_out[3], seg_out[2]};
    end else begin
      a_end = {8'h00, seg_out[3]};
    end
    // group B runs in series when the aux bus is driven
    b_src  = cfg_i.aux_drive ? a_end : {8'h00, aux_pixel_bus_i};
    row[0] = px;
    if (cfg_i.pix16) begin
      seg_in[0] = px[7:0];
      seg_in[1] = px[15:8];
      seg_in[2] = seg_out[0];
      seg_in[3] = seg_out[1];
      seg_in[4] = b_src[7:0];
      seg_in[5] = b_src[15:8];
      row[1]    = {seg_out[1], seg_out[0]};
      row[2]    = b_byp ? b_src : {seg_out[5], seg_out[4]};
      seg_in[6] = row[2][7:0];
      seg_in[7] = row[2][15:8];
      row[3]    = {seg_out[7], seg_out[6]};
    end else if (deep8) begin
      seg_in[0] = px[7:0];
      seg_in[4] = b_src[7:0];
      for (int i = 1; i < 4; i++) begin
        seg_in[i] = seg_out[i-1];
        row[i]    = {8'h00, seg_out[i-1]};
      end
      row[4]    = b_byp ? b_src : {8'h00, seg_out[4]};
      seg_in[5] = row[4][7:0];
      seg_in[6] = seg_out[5];
      seg_in[7] = seg_out[6];
      for (int i = 5; i < `IMCV_WIN; i++) begin
        row[i] = {8'h00, seg_out[i]};
      end
    end else begin
      seg_in[0] = px[7:0];
      seg_in[1] = seg_out[0];
      seg_in[2] = seg_out[1];
      seg_in[3] = seg_out[2];
      seg_in[4] = b_src[7:0];
      seg_in[5] = seg_out[4];
      row[1]    = {8'h00, seg_out[1]};
      row[2]    = b_byp ? b_src : {8'h00, seg_out[5]};
      seg_in[6] = row[2][7:0];
      seg_in[7] = seg_out[6];
      row[3]    = {8'h00, seg_out[7]};
    end
  end

  // ****************************************************************
  // window shift register
  // ****************************************************************
  logic [15:0] win_ff [`IMCV_WIN][`IMCV_WIN];

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int r = 0; r < `IMCV_WIN; r++) begin
        for (int c = 0; c < `IMCV_WIN; c++) begin
          win_ff[r][c] <= '0;
        end
      end
    end else if (pix_en) begin
      for (int r = 0; r < `IMCV_WIN; r++) begin
        win_ff[r][0] <= row[r];
        for (int c = 1; c < `IMCV_WIN; c++) begin
          win_ff[r][c] <= win_ff[r][c-1];
        end
      end
    end
  end

  // ****************************************************************
  // multiplier array, reused once per pass
  // ****************************************************************
  logic signed [15:0] prod   [`IMCV_NMUL];
  logic               prod_hi[`IMCV_NMUL];

  genvar gm;
  generate
    for (gm = 0; gm < `IMCV_NMUL; gm++) begin : g_mul
      logic [5:0]         slot;
      logic [2:0]         r_sel;
      logic [2:0]         c_sel;
      logic [15:0]        pel;
      logic signed [8:0]  opa;
      logic signed [16:0] full;
      assign slot = {ph_ff, 4'(gm)};
      always_comb begin
        if (cfg_i.pix16) begin
          r_sel = {1'b0, slot[2:1]};
          c_sel = slot[5:3];
          prod_hi[gm] = slot[0];
        end else begin
          r_sel = slot[5:3];
          c_sel = slot[2:0];
          prod_hi[gm] = 1'b0;
        end
        pel = win_ff[r_sel][c_sel];
        opa = prod_hi[gm] ? {pel[15], pel[15:8]} : {1'b0, pel[7:0]};
        full = opa * $signed(coef_ff[{r_sel, c_sel}]);
        prod[gm] = full[15:0];
      end
    end
  endgenerate

  // ****************************************************************
  // accumulator
  // ****************************************************************
  logic signed [`IMCV_ACC_W-1:0] psum;
  logic signed [`IMCV_ACC_W-1:0] acc_ff;
  logic signed [`IMCV_ACC_W-1:0] nxt_acc;
  logic signed [`IMCV_ACC_W-1:0] res_ff;
  logic signed [`IMCV_ACC_W-1:0] nxt_res;
  logic                          new_ff;

  always_comb begin
    psum = '0;
    for (int m = 0; m < `IMCV_NMUL; m++) begin
      if (prod_hi[m]) begin
        psum = psum + ({{16{prod[m][15]}}, prod[m]} <<< 8);
      end else begin
        psum = psum + {{16{prod[m][15]}}, prod[m]};
      end
    end
    nxt_acc = ((ph_ff == 2'h0) ? '0 : acc_ff) + psum;
    nxt_res = pix_en ? nxt_acc : res_ff;
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      acc_ff <= '0;
      res_ff <= '0;
      new_ff <= 1'b0;
    end else begin
      acc_ff <= nxt_acc;
      res_ff <= nxt_res;
      new_ff <= pix_en;
    end
  end

  // ****************************************************************
  // gain, saturation and threshold
  // ****************************************************************
  logic signed [`IMCV_FIELD_W-1:0] field;
  logic signed [`IMCV_GPROD_W:0]   gfull;
  logic        [`IMCV_GPROD_W-1:0] gprod;
  logic                            gain_ovf;
  logic        [15:0]              sat_out;
  logic        [15:0]              out_ff;
  logic                            ovf_ff;
  logic                            above_ff;
  logic        [7:0]               aux_ff;
  logic                            aux_oe_ff;

  always_comb begin
    unique case (cfg_i.field_select_bits)
      2'h0: field = res_ff[31:12];
      2'h1: field = res_ff[27:8];
      2'h2: field = res_ff[23:4];
      2'h3: field = res_ff[19:0];
    endcase
    gfull    = field * $signed({1'b0, cfg_i.gain});
    gprod    = gfull[`IMCV_GPROD_W-1:0];
    gain_ovf = (gprod[23:19] != {5{gprod[23]}});
    sat_out  = gprod[19:4];
    unique case (cfg_i.saturation_mode_bits)
      `IMCV_SAT_DISPLAY: begin
        if (gprod[23]) begin
          sat_out = '0;
        end else if (gain_ovf) begin
          sat_out = `IMCV_POS_MAX;
        end
      end
      `IMCV_SAT_SYMM: begin
        if (gain_ovf) begin
          sat_out = gprod[23] ? `IMCV_NEG_MAX : `IMCV_POS_MAX;
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      out_ff    <= '0;
      ovf_ff    <= 1'b0;
      above_ff  <= 1'b0;
      aux_ff    <= '0;
      aux_oe_ff <= 1'b0;
    end else begin
      if (new_ff) begin
        out_ff   <= sat_out;
        ovf_ff   <= gain_ovf;
        above_ff <= $signed(sat_out) > $signed(cfg_i.threshold);
      end
      aux_ff    <= a_end[7:0];
      // input after reset, output on bit
      aux_oe_ff <= cfg_i.aux_drive;
    end
  end

  assign aux_pixel_bus_o      = aux_ff;
  assign aux_pixel_bus_oe_o   = aux_oe_ff;
  assign pix_tick_o           = tick_ff;
  assign result_output_bus_o  = out_ff;
  assign gain_overflow_flag_o = ovf_ff;
  assign above_thresh_o       = above_ff;
  assign result_valid_o       = new_ff;

endmodule // imcv_core

// ===== testbench/imcv_core_sva.sv
/*
  port checker of the convolver core: pixel tick spacing, result timing,
  saturation clamps, threshold flag and aux drive.
  assumes: bound to imcv_core; cfg_i only changes while reset is held.
*/
`timescale 1ns/1ps
`include "imcv_defs.svh"

module imcv_core_sva import imcv_pkg::*; (
  // clock and reset
  input wire logic        clk_sys_i,
  input wire logic        sys_rst_i,
  // watched ports
  input wire imcv_cfg_s   cfg_i,
  input wire logic        pix_tick_o,
  input wire logic        result_valid_o,
  input wire logic [15:0] result_output_bus_o,
  input wire logic        gain_overflow_flag_o,
  input wire logic        above_thresh_o,
  input wire logic        aux_pixel_bus_oe_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  // ****************************************************************
  // sequences and assertions
  // ****************************************************************
  sequence s_gap2; !pix_tick_o ##1 pix_tick_o; endsequence
  sequence s_gap4; !pix_tick_o [*3] ##1 pix_tick_o; endsequence
  sequence s_pulse; result_valid_o ##1 !result_valid_o; endsequence

  a_tick_x2: assert property (pix_tick_o && !cfg_i.quad_clk |=> s_gap2)
    else $error("pixel tick spacing wrong at two passes");
  a_tick_x4: assert property (pix_tick_o && cfg_i.quad_clk |=> s_gap4)
    else $error("pixel tick spacing wrong at four passes");
  a_valid_follows: assert property (pix_tick_o |=> s_pulse)
    else $error("no single result pulse after pixel tick");
  // outputs must not drift between results, or downstream latches garbage
  a_out_hold: assert property (!result_valid_o |=> $stable(result_output_bus_o)
    && $stable(gain_overflow_flag_o) && $stable(above_thresh_o))
    else $error("result outputs changed without result pulse");
  a_thresh_cmp: assert property ($past(result_valid_o) |-> above_thresh_o ==
    ($signed(result_output_bus_o) > $signed(cfg_i.threshold)))
    else $error("threshold flag disagrees with result");
  a_display_pos: assert property ($past(result_valid_o) &&
    cfg_i.saturation_mode_bits == `IMCV_SAT_DISPLAY |-> !result_output_bus_o[15])
    else $error("negative result in display mode");
  a_display_ovf: assert property ($past(result_valid_o) && gain_overflow_flag_o &&
    cfg_i.saturation_mode_bits == `IMCV_SAT_DISPLAY
    |-> result_output_bus_o inside {16'h0, `IMCV_POS_MAX})
    else $error("display overflow not clamped");
  a_symm_clamp: assert property ($past(result_valid_o) && gain_overflow_flag_o &&
    cfg_i.saturation_mode_bits == `IMCV_SAT_SYMM
    |-> result_output_bus_o inside {`IMCV_NEG_MAX, `IMCV_POS_MAX})
    else $error("symmetric overflow not clamped");
  a_gain_zero: assert property ($past(result_valid_o) && cfg_i.gain == 4'h0
    |-> result_output_bus_o == 16'h0 && !gain_overflow_flag_o)
    else $error("zero gain gave nonzero output");
  a_aux_quiet: assert property (!cfg_i.aux_drive |-> !aux_pixel_bus_oe_o)
    else $error("aux bus driven without mode bit");
endmodule // imcv_core_sva

bind imcv_core imcv_core_sva u_sva (.clk_sys_i, .sys_rst_i, .cfg_i, .pix_tick_o,
  .result_valid_o, .result_output_bus_o, .gain_overflow_flag_o, .above_thresh_o,
  .aux_pixel_bus_oe_o);

// ===== testbench/imcv_px_src.sv
/*
  video source model: one pixel per device tick on both pixel buses,
  and the field-driven bypass pin.
  assumes: tick_i is the core's pix_tick_o; the bench resolves the aux bus.
*/
`timescale 1ns/1ps

module imcv_px_src (
  // clock and control
  input  wire logic        clk_sys_i,
  input  wire logic        tick_i,
  input  wire logic [15:0] level_i,
  input  wire logic        upper_field_i,
  // pixel and pin drive
  output logic      [15:0] main_px_o,
  output logic      [7:0]  aux_px_o,
  output logic             bypass_o
);
  // ****************************************************************
  // drive
  // ****************************************************************
  initial begin
    main_px_o = 16'h0;
    aux_px_o  = 8'h0;
    bypass_o  = 1'b0;
  end
  // off-tick cycles carry the inverse so a misplaced sample shows up
  always @(negedge clk_sys_i) begin
    main_px_o <= tick_i ? level_i : ~level_i;
    aux_px_o  <= tick_i ? level_i[7:0] : ~level_i[7:0];
    // extra delay only in upper field
    bypass_o  <= ~upper_field_i;
  end
endmodule // imcv_px_src

// ===== testbench/tb_top.sv
/*
  self-checking bench of the convolver core: constant pixel fields so every
  window tap behind a filled delay is equal and the sum is pixel times coefficient total.
  assumes: a fresh reset per configuration; two-pixel lines unless a delay is under test.
*/
`timescale 1ns/1ps
`include "imcv_defs.svh"

module tb_top import imcv_pkg::*;;
  logic          clk_sys_i = 1'b0;
  logic          sys_rst_i = 1'b1;
  imcv_cfg_s     cfg       = '0;
  imcv_coef_wr_s coef_wr   = '0;
  logic [15:0]   lvl       = 16'h0;
  logic          upper     = 1'b1;
  logic [15:0]   main_px;
  logic [7:0]    src_aux, dut_aux, aux_bus;
  logic          bypass, dut_oe, pix_tick_o, result_valid_o;
  logic          gain_overflow_flag_o, above_thresh_o;
  logic [15:0]   result_output_bus_o;
  logic [7:0]    tab [64];
  int            errors = 0, n_tests = 0, cyc = 0;

  always #10 clk_sys_i = ~clk_sys_i;
  assign aux_bus = dut_oe ? dut_aux : src_aux;

  imcv_core dut (.clk_sys_i, .sys_rst_i, .cfg_i(cfg), .coef_wr_i(coef_wr),
    .main_px_i(main_px), .aux_pixel_bus_i(aux_bus), .bypass_i(bypass),
    .aux_pixel_bus_o(dut_aux), .aux_pixel_bus_oe_o(dut_oe), .pix_tick_o,
    .result_output_bus_o, .gain_overflow_flag_o, .above_thresh_o, .result_valid_o);
  imcv_px_src src (.clk_sys_i, .tick_i(pix_tick_o), .level_i(lvl), .upper_field_i(upper),
    .main_px_o(main_px), .aux_px_o(src_aux), .bypass_o(bypass));

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic tally_and_finish();
    if (errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // a hung tick or result pulse must not stall the run
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wait_res();
    int t;
    t = 0;
    while (result_valid_o !== 1'b1 && t < 10) begin
      @(negedge clk_sys_i);
      t++;
    end
    chk("result_valid", 16'h1, {15'h0, result_valid_o});
    @(negedge clk_sys_i);
  endtask
  task automatic run(input imcv_cfg_s c, input logic [15:0] px, input logic [31:0] res);
    logic signed [19:0] fld;
    logic signed [23:0] p;
    logic [15:0]        o;
    logic               ov;
    cfg = c;
    lvl = px;
    sys_rst_i = 1'b1;
    repeat (16) @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    for (int k = 0; k < 64; k++) begin
      coef_wr = '{1'b1, 6'(k), tab[k]};
      @(negedge clk_sys_i);
    end
    coef_wr.we = 1'b0;
    repeat (40) wait_res();
    fld = res[31-4*c.field_select_bits -: 20];
    p = fld * $signed({1'b0, c.gain});
    ov = p[23:19] != 5'h0 && p[23:19] != 5'h1f;
    o = p[19:4];
    if (c.saturation_mode_bits == `IMCV_SAT_DISPLAY && p[23]) o = 16'h0;
    else if (c.saturation_mode_bits == `IMCV_SAT_DISPLAY && ov) o = `IMCV_POS_MAX;
    if (c.saturation_mode_bits == `IMCV_SAT_SYMM && ov) o = p[23] ? `IMCV_NEG_MAX : `IMCV_POS_MAX;
    chk("result", o, result_output_bus_o);
    chk("overflow", {15'h0, ov}, {15'h0, gain_overflow_flag_o});
    chk("above", {15'h0, $signed(o) > $signed(c.threshold)}, {15'h0, above_thresh_o});
    chk("aux_oe", {15'h0, c.aux_drive}, {15'h0, dut_oe});
    if (c.aux_drive) chk("aux_data", {8'h0, px[7:0]}, {8'h0, dut_aux});
  endtask
  function automatic imcv_cfg_s base();
    base = '0;
    base.line_len = 11'h2;
    base.gain = 4'h1;
    base.field_select_bits = 2'h3;
  endfunction
  task automatic fill_fields();
    tab = '{default: 8'h0};
    tab[6'h00] = 8'h20;
    tab[6'h09] = 8'h10;
    tab[6'h17] = 8'hf8;
    tab[6'h1b] = 8'h08;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic sc_coef_reset();
    tab = '{default: 8'h0};
    run(base(), 16'h55, 32'h0);
  endtask
  task automatic sc_fields();
    imcv_cfg_s b;
    fill_fields();
    for (int f = 0; f < 4; f++) begin
      b = base();
      b.field_select_bits = 2'(f);
      run(b, 16'hc8, 32'h2580);
    end
    b = base();
    b.gain = 4'h0;
    run(b, 16'hc8, 32'h2580);
    b.gain = 4'hf;
    run(b, 16'hc8, 32'h2580);
  endtask
  task automatic sc_saturate();
    imcv_cfg_s b;
    for (int m = 0; m < 4; m++) begin
      b = base();
      b.saturation_mode_bits = 2'(m);
      b.threshold = 16'hff00;
      b.gain = 4'hf;
      tab = '{default: 8'h0};
      for (int k = 0; k < 8; k++) tab[k] = 8'h80;
      run(b, 16'hff, 32'hfffc0400);
      b.gain = 4'h1;
      run(b, 16'hff, 32'hfffc0400);
      for (int k = 0; k < 8; k++) tab[k] = 8'h7f;
      b.gain = 4'hf;
      run(b, 16'hff, 32'h0003f408);
    end
  endtask
  task automatic sc_thresh();
    imcv_cfg_s b;
    fill_fields();
    b = base();
    b.threshold = 16'h0258;
    run(b, 16'hc8, 32'h2580);
    b.threshold = 16'h0257;
    run(b, 16'hc8, 32'h2580);
  endtask
  task automatic sc_x4_aux();
    imcv_cfg_s b;
    fill_fields();
    b = base();
    b.quad_clk = 1'b1;
    b.aux_drive = 1'b1;
    b.b_first_skip = 1'b1;
    upper = 1'b0;
    run(b, 16'hc8, 32'h2580);
    upper = 1'b1;
    b.deep8 = 1'b1;
    b.aux_drive = 1'b0;
    tab[6'h2a] = 8'h10;
    run(b, 16'hc8, 32'h3200);
  endtask
  task automatic sc_pix16();
    imcv_cfg_s b;
    tab = '{default: 8'h0};
    tab[6'h00] = 8'h02;
    tab[6'h03] = 8'hff;
    b = base();
    b.pix16 = 1'b1;
    run(b, 16'h8123, 32'hffff8123);
  endtask
  // long delay: the unbypassed B tap still reads cleared storage when judged
  task automatic sc_bypass();
    imcv_cfg_s b;
    tab = '{default: 8'h0};
    tab[6'h10] = 8'h10;
    b = base();
    b.line_len = 11'h100;
    b.b_first_skip = 1'b1;
    run(b, 16'hc8, 32'hc80);
    b.b_first_skip = 1'b0;
    upper = 1'b0;
    run(b, 16'hc8, 32'hc80);
    upper = 1'b1;
    run(b, 16'hc8, 32'h0);
  endtask

  initial begin
    sc_coef_reset();
    sc_fields();
    sc_saturate();
    sc_thresh();
    sc_x4_aux();
    sc_pix16();
    sc_bypass();
    tally_and_finish();
  end
endmodule // tb_top
